// file: rtl/cgpc_pkg.sv
/*
 * constants, state enumeration and state record of the clock generator
 * pll control block; assumes byte-wide register access on one clock
 */
package cgpc_pkg;

   // *****************************************************************
   // register map
   // *****************************************************************
   localparam logic [7:0] ADDR_PLL_CFG  = 8'h34;
   localparam logic [7:0] ADDR_PLL_STAT = 8'h35;
   localparam logic [7:0] CFG_RESET     = 8'hc0;
   localparam logic [7:0] STAT_RESET    = 8'h00;
   // status bits 1..5 are writable, 0 and 6 are live, 7 reads zero
   localparam logic [7:0] STAT_WMASK    = 8'h3e;

   // *****************************************************************
   // field positions
   // *****************************************************************
   localparam int SRC_LSB        = 0;
   localparam int TOUCH_RATE_BIT = 3;
   localparam int SPREAD_DEP_BIT = 4;
   localparam int SPREAD_EN_BIT  = 5;
   localparam int SYS_OUT_BIT    = 6;
   localparam int USB_OUT_BIT    = 7;
   localparam int LOCKED_BIT     = 0;
   localparam int REF_A_BIT      = 1;
   localparam int REF_B_BIT      = 2;
   localparam int SLOW_A_BIT     = 4;
   localparam int SLOW_B_BIT     = 5;
   localparam int OSC_STABLE_BIT = 6;

   // *****************************************************************
   // source select codes and decoded reference
   // *****************************************************************
   localparam logic [2:0] SRC_OFF_A  = 3'h0;
   localparam logic [2:0] SRC_26M_A  = 3'h1;
   localparam logic [2:0] SRC_32K    = 3'h2;
   localparam logic [2:0] SRC_26M_B  = 3'h3;
   localparam logic [2:0] SRC_OFF_B  = 3'h4;
   localparam logic [2:0] SRC_12M    = 3'h5;
   localparam logic [2:0] SRC_13M    = 3'h6;
   localparam logic [2:0] SRC_19M2   = 3'h7;
   localparam logic [2:0] REF_NONE   = 3'h0;
   localparam logic [2:0] REF_26M    = 3'h1;
   localparam logic [2:0] REF_32K    = 3'h2;
   localparam logic [2:0] REF_12M    = 3'h3;
   localparam logic [2:0] REF_13M    = 3'h4;
   localparam logic [2:0] REF_19M2   = 3'h5;

   // *****************************************************************
   // timing
   // *****************************************************************
   localparam int CLK_PERIOD_NS  = 20;
   localparam int PWR_HOLD_NS    = 1000;
   localparam logic [7:0] PWR_HOLD_CYC =
      8'(PWR_HOLD_NS / CLK_PERIOD_NS);
   localparam logic [3:0] LOCK_BLANK_CYC = 4'h8;

   typedef enum logic [1:0] {PS_ON, PS_DRAIN, PS_OFF} cgpc_pwr_t;

   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] stat_rw;
      logic [2:0] ref_sel;
      logic       pll_power;
      logic       lock_s1;
      logic       lock_s2;
      logic       osc_s1;
      logic       osc_s2;
      logic       pll_locked;
      logic       osc_stable;
      logic [3:0] blank_cnt;
      cgpc_pwr_t  pstate;
      logic [7:0] hold_cnt;
      logic       power_on;
      logic       gen_powered;
      logic [7:0] rdata;
   } cgpc_state_t;

endpackage : cgpc_pkg

// file: rtl/cgpc_ctrl.sv
/*
 * pll configuration, status and power-state control of the clock
 * generator; assumes a byte register port on clk (the i2c slave and the
 * processor bus both land here) and raw analog lock / stability levels
 */
`timescale 1ns/1ns
`default_nettype none

// Function
// - source select in config bits 2:0 controls pll power, codes 0 and 4 keep it off, reset 0.
// - codes 1 and 3 power the pll from a 26 MHz reference on the ref clock input.
// - code 2 powers the pll from the 32 kHz slow crystal input.
// - codes 5, 6 and 7 power the pll from 12, 13 or 19.2 MHz on the ref clock input.
// - config bit 3 picks the touch clock, 2 MHz at 0 and 1 MHz at 1, reset 0.
// - config bit 4 picks spread depth, 1 percent at 0 and 2 percent at 1, reset 0.
// - config bit 5 turns spread modulation of the 24 MHz converter clock on, reset off.
// - config bits 7 and 6 enable their clock outputs independently.
// - bit 6 gates the system clock and bit 7 the usb clock, both reset to 1.
// - status bit 0 is read-only and shows pll lock, reset 0.
// - status bit 6 is read-only and shows slow oscillator stability.
// - a pending processor interrupt sets the power-on bit.
// - writing 1 to the power-on bit clears it.
// - power stays on for a short hold after the power-on bit clears.
// - while powered the 8 MHz clock runs and the pll stays off until selected.
module cgpc_ctrl
   import cgpc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output var  logic [7:0] reg_rdata,
   input  wire logic       power_clear_wr,
   input  wire logic       cpu_irq_pending,
   input  wire logic       pll_lock_raw,
   input  wire logic       slow_osc_raw,
   output var  logic       pll_power_up,
   output var  logic [2:0] pll_ref_select,
   output var  logic       touch_clock_rate,
   output var  logic       spread_depth,
   output var  logic       spread_enable,
   output var  logic       system_clock_out_enable,
   output var  logic       usb_clock_out_enable,
   output var  logic       ref_out_a_enable,
   output var  logic       ref_out_b_enable,
   output var  logic       slow_out_a_enable,
   output var  logic       slow_out_b_enable,
   output var  logic       clockgen_power_on,
   output var  logic       clockgen_powered
);

   // *****************************************************************
   // state
   // *****************************************************************
   cgpc_state_t st;
   cgpc_state_t next_st;
   logic        wr_cfg;
   logic        wr_stat;
   logic        ref_change;

   assign wr_cfg  = reg_wr && (reg_addr == ADDR_PLL_CFG);
   assign wr_stat = reg_wr && (reg_addr == ADDR_PLL_STAT);
   assign ref_change = wr_cfg &&
      (reg_wdata[SRC_LSB +: 3] != st.cfg[SRC_LSB +: 3]);

   always_comb begin
      next_st = st;

      // *****************************************************************
      // register writes
      // *****************************************************************
      // writable config byte
      if (wr_cfg) begin
         next_st.cfg = reg_wdata;
      end
      if (wr_stat) begin
         next_st.stat_rw = reg_wdata & STAT_WMASK;
      end

      // *****************************************************************
      // source decode
      // *****************************************************************
      // off codes keep the pll unpowered
      next_st.pll_power = 1'b1;
      next_st.ref_sel   = REF_NONE;
      case (next_st.cfg[SRC_LSB +: 3])
         SRC_OFF_A, SRC_OFF_B: begin
            next_st.pll_power = 1'b0;
         end
         // 26 MHz from the ref clock input
         SRC_26M_A, SRC_26M_B: begin
            next_st.ref_sel = REF_26M;
         end
         SRC_32K: begin
            next_st.ref_sel = REF_32K;
         end
         SRC_12M: begin
            next_st.ref_sel = REF_12M;
         end
         SRC_13M: begin
            next_st.ref_sel = REF_13M;
         end
         SRC_19M2: begin
            next_st.ref_sel = REF_19M2;
         end
         default: begin
            next_st.pll_power = 1'b0;
         end
      endcase

      // *****************************************************************
      // lock and stability sampling
      // *****************************************************************
      // analog levels are asynchronous, so two flops before any use
      next_st.lock_s1 = pll_lock_raw;
      next_st.lock_s2 = st.lock_s1;
      next_st.osc_s1  = slow_osc_raw;
      next_st.osc_s2  = st.osc_s1;
      next_st.osc_stable = st.osc_s2;

      // blank lock after a reference change
      if (ref_change) begin
         next_st.blank_cnt = LOCK_BLANK_CYC;
      end else if (st.blank_cnt != 4'h0) begin
         next_st.blank_cnt = st.blank_cnt - 4'h1;
      end
      // lock only while powered and not blanked
      next_st.pll_locked = st.lock_s2 && next_st.pll_power &&
                           !ref_change && (st.blank_cnt == 4'h0);

      // *****************************************************************
      // power state
      // *****************************************************************
      // the hold lets an access already on the bus finish before the
      // generator (and with it this clock) stops
      case (st.pstate)
         PS_ON: begin
            // write 1 clears the power-on bit
            if (power_clear_wr && !cpu_irq_pending) begin
               next_st.pstate   = PS_DRAIN;
               next_st.power_on = 1'b0;
               next_st.hold_cnt = PWR_HOLD_CYC;
            end
         end
         PS_DRAIN: begin
            if (st.hold_cnt == 8'h01) begin
               next_st.pstate      = PS_OFF;
               next_st.gen_powered = 1'b0;
            end
            next_st.hold_cnt = st.hold_cnt - 8'h01;
         end
         PS_OFF: begin
            next_st.gen_powered = 1'b0;
         end
         default: begin
            next_st.pstate = PS_ON;
         end
      endcase
      // a pending interrupt sets power-on and wins over the clear
      if (cpu_irq_pending) begin
         next_st.pstate      = PS_ON;
         next_st.power_on    = 1'b1;
         next_st.gen_powered = 1'b1;
         next_st.hold_cnt    = 8'h00;
      end

      // *****************************************************************
      // read data
      // *****************************************************************
      if (reg_rd) begin
         case (reg_addr)
            ADDR_PLL_CFG: begin
               next_st.rdata = st.cfg;
            end
            // lock and stability are not writable
            ADDR_PLL_STAT: begin
               next_st.rdata = st.stat_rw;
               next_st.rdata[LOCKED_BIT]     = st.pll_locked;
               next_st.rdata[OSC_STABLE_BIT] = st.osc_stable;
            end
            default: begin
               next_st.rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st             <= '0;
         // both clock outputs enabled out of reset
         st.cfg         <= CFG_RESET;
         st.stat_rw     <= STAT_RESET;
         st.pstate      <= PS_ON;
         // generator runs out of reset, pll stays off
         st.power_on    <= 1'b1;
         st.gen_powered <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // *****************************************************************
   // outputs
   // *****************************************************************
   assign reg_rdata               = st.rdata;
   assign pll_power_up            = st.pll_power;
   assign pll_ref_select          = st.ref_sel;
   assign touch_clock_rate        = st.cfg[TOUCH_RATE_BIT];
   assign spread_depth            = st.cfg[SPREAD_DEP_BIT];
   // spread enable straight from its bit
   assign spread_enable           = st.cfg[SPREAD_EN_BIT];
   // each output enable from its own bit
   assign system_clock_out_enable = st.cfg[SYS_OUT_BIT];
   assign usb_clock_out_enable    = st.cfg[USB_OUT_BIT];
   assign ref_out_a_enable        = st.stat_rw[REF_A_BIT];
   assign ref_out_b_enable        = st.stat_rw[REF_B_BIT];
   assign slow_out_a_enable       = st.stat_rw[SLOW_A_BIT];
   assign slow_out_b_enable       = st.stat_rw[SLOW_B_BIT];
   assign clockgen_power_on       = st.power_on;
   assign clockgen_powered        = st.gen_powered;

   // *****************************************************************
   // assertions
   // *****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // *****************************************************************
   // hold tracking for the power assertions
   // *****************************************************************
   // counts cycles with the on-bit low but the generator still powered;
   // a small counter stands in for a long repetition of the hold
   logic [7:0] drain_seen;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         drain_seen <= 8'h00;
      end else if (clockgen_power_on) begin
         drain_seen <= 8'h00;
      end else if (clockgen_powered && (drain_seen != 8'hff)) begin
         drain_seen <= drain_seen + 8'h01;
      end
   end

   a_pll_off_codes: assert property (
      (st.cfg[1:0] == 2'b00) |-> !pll_power_up)
      else $error("pll powered on an off code");
   a_ref_26m_decode: assert property (
      wr_cfg && (reg_wdata[2:0] inside {3'h1, 3'h3})
      |=> pll_power_up && (pll_ref_select == REF_26M))
      else $error("26 MHz code not decoded");
   a_ref_32k_decode: assert property (
      wr_cfg && (reg_wdata[2:0] == 3'h2)
      |=> pll_power_up && (pll_ref_select == REF_32K))
      else $error("32 kHz code not decoded");
   a_ref_fast_decode: assert property (
      wr_cfg && (reg_wdata[2:0] == 3'h7)
      |=> (pll_ref_select == REF_19M2))
      else $error("19.2 MHz code not decoded");
   a_cfg_write_bits: assert property (
      wr_cfg |=> (system_clock_out_enable == $past(reg_wdata[6])) &&
                 (usb_clock_out_enable == $past(reg_wdata[7])) &&
                 (touch_clock_rate == $past(reg_wdata[3])))
      else $error("config write not reflected on outputs");
   a_lock_readback: assert property (
      reg_rd && (reg_addr == ADDR_PLL_STAT)
      |=> reg_rdata[0] == $past(st.pll_locked))
      else $error("status read lost the lock bit");
   a_stable_sync: assert property (
      $rose(slow_osc_raw) ##1 slow_osc_raw[*3] |-> st.osc_stable)
      else $error("stability not seen after three cycles");
   a_irq_powers_on: assert property (
      cpu_irq_pending |=> clockgen_power_on && clockgen_powered)
      else $error("pending interrupt did not power the generator");
   a_clear_write: assert property (
      clockgen_power_on && power_clear_wr && !cpu_irq_pending
      |=> !clockgen_power_on)
      else $error("clear write did not clear power-on");
   // a drop that comes early would cut an access still on the bus, one
   // that never comes wastes the supply the clear was meant to save
   a_power_hold: assert property (
      $fell(clockgen_powered) |-> (drain_seen == PWR_HOLD_CYC))
      else $error("generator dropped before the hold ran out");
   a_power_drops: assert property (
      !clockgen_power_on && clockgen_powered
      |-> (drain_seen < PWR_HOLD_CYC))
      else $error("generator stayed powered past the hold");
   a_lock_blank: assert property (
      ref_change |=> !st.pll_locked [*8])
      else $error("lock shown inside the blanking time");

   // the raw lock level may stay high across a reference change, so the
   // flag must follow power and the synchroniser, not the pin alone
   a_off_no_lock: assert property (
      !pll_power_up |-> !st.pll_locked)
      else $error("lock shown with the pll off");
   a_lock_after_sync: assert property (
      st.pll_locked |-> $past(pll_lock_raw, 3))
      else $error("lock shown before the raw level was synchronised");
   a_ref_12m_decode: assert property (
      wr_cfg && (reg_wdata[2:0] == 3'h5)
      |=> pll_power_up && (pll_ref_select == REF_12M))
      else $error("12 MHz code not decoded");
   a_ref_13m_decode: assert property (
      wr_cfg && (reg_wdata[2:0] == 3'h6)
      |=> pll_power_up && (pll_ref_select == REF_13M))
      else $error("13 MHz code not decoded");
   a_spread_bits: assert property (
      wr_cfg |=> (spread_depth == $past(reg_wdata[SPREAD_DEP_BIT])) &&
                 (spread_enable == $past(reg_wdata[SPREAD_EN_BIT])))
      else $error("spread bits not taken from the write");
   a_stable_readback: assert property (
      reg_rd && (reg_addr == ADDR_PLL_STAT)
      |=> (reg_rdata[OSC_STABLE_BIT] == $past(st.osc_stable)) &&
          !reg_rdata[7])
      else $error("status read lost the stability bit");
   a_irq_beats_clear: assert property (
      cpu_irq_pending && power_clear_wr |=> clockgen_power_on)
      else $error("clear won over a pending interrupt");
   a_off_stays_down: assert property (
      (st.pstate == PS_OFF) && !cpu_irq_pending |=> !clockgen_powered)
      else $error("generator powered again without an interrupt");

   // *****************************************************************
   // cover points
   // *****************************************************************
   c_pll_lock: cover property (pll_power_up ##1 st.pll_locked);
   c_power_down: cover property ($fell(clockgen_powered));
   c_irq_wake: cover property (
      (st.pstate == PS_DRAIN) ##1 cpu_irq_pending);
   c_ref_change: cover property (
      ref_change ##1 (st.blank_cnt == LOCK_BLANK_CYC));
   c_irq_and_clear: cover property (cpu_irq_pending && power_clear_wr);

endmodule : cgpc_ctrl

`default_nettype wire

// file: testbench/cgpc_pll_model.sv
/*
 * behavioural pll and slow oscillator beside the clock generator control;
 * assumes the control block's clk and active-low reset
 */
`timescale 1ns/1ns
`default_nettype none
module cgpc_pll_model #(
   parameter int LOCK_DLY = 20,
   parameter int OSC_DLY  = 30
) (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       pll_power_up,
   input  wire logic [2:0] pll_ref_select,
   output var  logic       pll_lock_raw,
   output var  logic       slow_osc_raw
);
   int         lock_cnt;
   int         osc_cnt;
   logic [2:0] last_ref;
   // lock is lost at once on power-down or a new reference
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lock_cnt <= 0;
         osc_cnt  <= 0;
         last_ref <= 3'h0;
      end else begin
         last_ref <= pll_ref_select;
         if (!pll_power_up || pll_ref_select != last_ref)
            lock_cnt <= 0;
         else if (lock_cnt < LOCK_DLY)
            lock_cnt <= lock_cnt + 1;
         if (osc_cnt < OSC_DLY)
            osc_cnt <= osc_cnt + 1;
      end
   end
   assign pll_lock_raw = (lock_cnt >= LOCK_DLY);
   assign slow_osc_raw = (osc_cnt >= OSC_DLY);
endmodule : cgpc_pll_model
`default_nettype wire

// file: testbench/clock_generator_pll_control_tb.sv
/*
 * self-checking bench of the clock generator pll control;
 * assumes the pll model file and the design package are compiled first
 */
`timescale 1ns/1ns
`default_nettype none
module clock_generator_pll_control_tb
   import cgpc_pkg::*;
;
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       power_clear_wr = 1'b0;
   logic       cpu_irq_pending = 1'b0;
   logic [7:0] reg_rdata;
   logic       pll_lock_raw, slow_osc_raw, pll_power_up;
   logic [2:0] pll_ref_select;
   logic       touch_clock_rate, spread_depth, spread_enable;
   logic       system_clock_out_enable, usb_clock_out_enable;
   logic       ref_out_a_enable, ref_out_b_enable;
   logic       slow_out_a_enable, slow_out_b_enable;
   logic       clockgen_power_on, clockgen_powered;
   int         failures = 0;
   int         n_compared = 0;
   logic [7:0] d;
   logic [7:0] exp_stat;
   // bench model of the two registers, kept by the write task
   int         model_cfg = int'(CFG_RESET);
   int         model_stat = int'(STAT_RESET);

   always #10 clk = ~clk;

   cgpc_ctrl DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .power_clear_wr(power_clear_wr),
      .cpu_irq_pending(cpu_irq_pending), .pll_lock_raw(pll_lock_raw),
      .slow_osc_raw(slow_osc_raw), .pll_power_up(pll_power_up),
      .pll_ref_select(pll_ref_select),
      .touch_clock_rate(touch_clock_rate), .spread_depth(spread_depth),
      .spread_enable(spread_enable),
      .system_clock_out_enable(system_clock_out_enable),
      .usb_clock_out_enable(usb_clock_out_enable),
      .ref_out_a_enable(ref_out_a_enable),
      .ref_out_b_enable(ref_out_b_enable),
      .slow_out_a_enable(slow_out_a_enable),
      .slow_out_b_enable(slow_out_b_enable),
      .clockgen_power_on(clockgen_power_on),
      .clockgen_powered(clockgen_powered));

   cgpc_pll_model pll (.clk(clk), .rst_b(rst_b),
      .pll_power_up(pll_power_up), .pll_ref_select(pll_ref_select),
      .pll_lock_raw(pll_lock_raw), .slow_osc_raw(slow_osc_raw));

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk) #1;
      reg_addr  = a;
      reg_wdata = v;
      reg_wr    = 1'b1;
      @(posedge clk) #1;
      reg_wr = 1'b0;
      if (a == ADDR_PLL_CFG) begin
         model_cfg = int'(v);
      end else if (a == ADDR_PLL_STAT) begin
         model_stat = int'(v & STAT_WMASK);
      end
      @(posedge clk) #1;
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk) #1;
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge clk) #1;
      reg_rd = 1'b0;
      chk(reg_rdata, exp);
   endtask : rd_chk

   task automatic pulse(input logic clr, input logic irq);
      @(posedge clk) #1;
      power_clear_wr  = clr;
      cpu_irq_pending = irq;
      @(posedge clk) #1;
      power_clear_wr  = 1'b0;
      cpu_irq_pending = 1'b0;
      @(posedge clk) #1;
   endtask : pulse

   // reference decode of the bench model, worked out by hand
   function automatic logic [3:0] pll_of(input logic [2:0] c);
      case (c)
         3'h1, 3'h3: pll_of = {1'b1, REF_26M};
         3'h2:       pll_of = {1'b1, REF_32K};
         3'h5:       pll_of = {1'b1, REF_12M};
         3'h6:       pll_of = {1'b1, REF_13M};
         3'h7:       pll_of = {1'b1, REF_19M2};
         default:    pll_of = {1'b0, REF_NONE};
      endcase
   endfunction : pll_of

   task automatic give_verdict;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict

   initial begin
      #(20 * 5000);
      failures++;
      give_verdict();
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      void'($urandom(32'h296ce622));
      repeat (10) @(posedge clk);
      #1 rst_b = 1'b1;
      chk({pll_power_up, pll_ref_select, usb_clock_out_enable,
           system_clock_out_enable, spread_enable, spread_depth}, 8'h0c);
      chk({clockgen_power_on, clockgen_powered, touch_clock_rate}, 8'h06);
      rd_chk(ADDR_PLL_CFG, 8'hc0);
      rd_chk(ADDR_PLL_STAT, 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         d[2:0] = 3'(i);
         wr(ADDR_PLL_CFG, d);
         chk(8'({pll_power_up, pll_ref_select}), 8'(pll_of(d[2:0])));
         chk({usb_clock_out_enable, system_clock_out_enable, spread_enable,
              spread_depth, touch_clock_rate, 3'h0}, {d[7:3], 3'h0});
         rd_chk(ADDR_PLL_CFG, 8'(model_cfg));
      end
      $display("test source codes done");
      exp_stat = 8'($urandom) & STAT_WMASK;
      wr(ADDR_PLL_STAT, exp_stat | 8'hc1);
      exp_stat = 8'(model_stat);
      chk({slow_out_b_enable, slow_out_a_enable, ref_out_b_enable,
           ref_out_a_enable, 4'h0}, {exp_stat[5:4], exp_stat[2:1], 4'h0});
      wr(8'h36, 8'hff);
      rd_chk(8'h36, 8'h00);
      wr(ADDR_PLL_CFG, 8'hc5);
      repeat (40) @(posedge clk);
      rd_chk(ADDR_PLL_STAT, exp_stat | 8'h41);
      wr(ADDR_PLL_CFG, 8'hc6);
      rd_chk(ADDR_PLL_STAT, exp_stat | 8'h40);
      wr(ADDR_PLL_CFG, 8'hc4);
      repeat (40) @(posedge clk);
      rd_chk(ADDR_PLL_STAT, exp_stat | 8'h40);
      $display("test status and lock done");
      // the power-state sequence is the last part of the run
      pulse(1'b1, 1'b1);
      chk({clockgen_power_on, clockgen_powered}, 8'h03);
      pulse(1'b1, 1'b0);
      chk({clockgen_power_on, clockgen_powered}, 8'h01);
      repeat (PWR_HOLD_CYC - 2) @(posedge clk);
      #1 chk(clockgen_powered, 8'h01);
      @(posedge clk) #1;
      chk(clockgen_powered, 8'h00);
      pulse(1'b0, 1'b1);
      chk({clockgen_power_on, clockgen_powered}, 8'h03);
      // an interrupt inside the hold keeps the generator up for good
      pulse(1'b1, 1'b0);
      pulse(1'b0, 1'b1);
      chk({clockgen_power_on, clockgen_powered}, 8'h03);
      repeat (PWR_HOLD_CYC + 5) @(posedge clk);
      #1 chk(clockgen_powered, 8'h01);
      $display("test power state done");
      give_verdict();
   end
endmodule : clock_generator_pll_control_tb
`default_nettype wire
